// ===== hdl/pcpio_crossbar.sv
// priority crossbar, pin configuration and port registers
`timescale 1ns/10ps
module pcpio_crossbar (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// special function register port
	input wire logic [7:0] regAddr,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic regRmw,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	// peripheral side
	input wire logic uartTx,
	output logic uartRx,
	input wire logic spiSck,
	output logic spiMisoIn,
	input wire logic spiMosi,
	input wire logic spiSlaveSel,
	input wire logic [1:0] slaveSelectMode,
	input wire logic mgmtSdaOut,
	output logic mgmtSdaIn,
	input wire logic mgmtSclOut,
	output logic mgmtSclIn,
	input wire logic sysClockOut,
	input wire logic cmpAsyncOut,
	input wire logic cmpSyncOut,
	// pins
	input wire logic [15:0] pinIn,
	output logic [15:0] pinOut,
	output logic [15:0] pinOe,
	output logic [15:0] pinPullup,
	output logic [15:0] pinDigIn
);
	logic [7:0] en0_r, en0_nxt, ctl1_r, ctl1_nxt;
	logic [15:0] mdin_r, mdin_nxt, mdout_r, mdout_nxt, skip_r, skip_nxt, latch_r, latch_nxt;
	logic [7:0] rdata_nxt;
	logic [15:0] out_nxt, oe_nxt, pu_nxt, din_nxt, drvOut, isOd, usedMask;
	logic [2:0] pinFunc [16];
	logic [15:0] pinIsMgmt;
	// peripheral input pins must never be driven, whatever their output mode
	logic [15:0] pinIsIn;
	logic [15:0] pinInQ;

	// register writes
	always_comb begin
		en0_nxt = en0_r;
		ctl1_nxt = ctl1_r;
		mdin_nxt = mdin_r;
		mdout_nxt = mdout_r;
		skip_nxt = skip_r;
		latch_nxt = latch_r;
		if (regWr) begin
			case (regAddr)
				pcpio_pkg::ADDR_XBR_EN0: en0_nxt = regWdata & pcpio_pkg::EN0_MASK;
				pcpio_pkg::ADDR_XBR_CTL1: ctl1_nxt = regWdata; // R19
				pcpio_pkg::ADDR_MDIN0: mdin_nxt[7:0] = regWdata; // R09
				pcpio_pkg::ADDR_MDIN1: mdin_nxt[15:8] = regWdata;
				pcpio_pkg::ADDR_MDOUT0: mdout_nxt[7:0] = regWdata;
				pcpio_pkg::ADDR_MDOUT1: mdout_nxt[15:8] = regWdata;
				pcpio_pkg::ADDR_SKIP0: skip_nxt[7:0] = regWdata;
				pcpio_pkg::ADDR_SKIP1: skip_nxt[15:8] = regWdata;
				pcpio_pkg::ADDR_PORT0: latch_nxt[7:0] = regWdata;
				pcpio_pkg::ADDR_PORT1: latch_nxt[15:8] = regWdata;
				default: ;
			endcase
		end
	end

	// reads: ports show pins, except read-modify-write sees the latch
	always_comb begin
		rdata_nxt = 8'h00;
		if (regRd) begin
			case (regAddr)
				pcpio_pkg::ADDR_XBR_EN0: rdata_nxt = en0_r;
				pcpio_pkg::ADDR_XBR_CTL1: rdata_nxt = ctl1_r;
				pcpio_pkg::ADDR_MDIN0: rdata_nxt = mdin_r[7:0];
				pcpio_pkg::ADDR_MDIN1: rdata_nxt = mdin_r[15:8];
				pcpio_pkg::ADDR_MDOUT0: rdata_nxt = mdout_r[7:0];
				pcpio_pkg::ADDR_MDOUT1: rdata_nxt = mdout_r[15:8];
				pcpio_pkg::ADDR_SKIP0: rdata_nxt = skip_r[7:0];
				pcpio_pkg::ADDR_SKIP1: rdata_nxt = skip_r[15:8];
				pcpio_pkg::ADDR_PORT0: rdata_nxt = regRmw ? latch_r[7:0] : pinInQ[7:0]; // R15 R20
				pcpio_pkg::ADDR_PORT1: rdata_nxt = regRmw ? latch_r[15:8] : pinInQ[15:8]; // R15 R20
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	// analog pins read as zero since their receiver is off
	always_comb pinInQ = pinIn & mdin_r; // R08

	// priority allocation; uart and comparators sit on fixed pins
	always_comb begin
		logic [2:0] want [8];
		int nw, k;
		logic en;
		nw = 0;
		k = 0;
		en = ctl1_r[pcpio_pkg::BIT_ROUTER];
		for (int i = 0; i < 8; i++) want[i] = 3'(pcpio_pkg::F_NONE);
		for (int p = 0; p < pcpio_pkg::NPINS; p++) pinFunc[p] = 3'(pcpio_pkg::F_NONE);
		usedMask = skip_r; // R02
		if (en && en0_r[pcpio_pkg::BIT_UART]) begin
			usedMask[pcpio_pkg::PIN_UTX] = 1'b1; // R03 R05
			usedMask[pcpio_pkg::PIN_URX] = 1'b1;
		end
		if (en && en0_r[pcpio_pkg::BIT_SPI]) begin
			want[0] = 3'(pcpio_pkg::F_SCK);
			want[1] = 3'(pcpio_pkg::F_MISO);
			want[2] = 3'(pcpio_pkg::F_MOSI);
			nw = 3;
			if (slaveSelectMode == pcpio_pkg::SS_FOUR_WIRE) begin
				want[3] = 3'(pcpio_pkg::F_NSS); // R07
				nw = 4;
			end
		end
		if (en && en0_r[pcpio_pkg::BIT_MGMT]) begin
			want[nw] = 3'(pcpio_pkg::F_SDA); // R05
			want[nw+1] = 3'(pcpio_pkg::F_SCL);
			nw = nw + 2;
		end
		if (en && en0_r[pcpio_pkg::BIT_SYSCK]) begin
			want[nw] = 3'(pcpio_pkg::F_SYSCK);
			nw = nw + 1;
		end
		// lowest free pin to each wanted function in turn
		for (int p = 0; p < pcpio_pkg::NPINS; p++) begin
			if (!usedMask[p] && k < nw) begin
				pinFunc[p] = want[k]; // R01
				usedMask[p] = 1'b1;
				k = k + 1;
			end
		end
	end

	// drive, mode and pull-up per pin
	always_comb begin
		logic en;
		en = ctl1_r[pcpio_pkg::BIT_ROUTER];
		for (int p = 0; p < pcpio_pkg::NPINS; p++) begin
			pinIsMgmt[p] = pinFunc[p] == 3'(pcpio_pkg::F_SDA) || pinFunc[p] == 3'(pcpio_pkg::F_SCL);
			pinIsIn[p] = pinFunc[p] == 3'(pcpio_pkg::F_MISO); // R01
			case (pinFunc[p])
				3'(pcpio_pkg::F_SCK): drvOut[p] = spiSck;
				3'(pcpio_pkg::F_MOSI): drvOut[p] = spiMosi;
				3'(pcpio_pkg::F_NSS): drvOut[p] = spiSlaveSel;
				3'(pcpio_pkg::F_SDA): drvOut[p] = mgmtSdaOut;
				3'(pcpio_pkg::F_SCL): drvOut[p] = mgmtSclOut;
				3'(pcpio_pkg::F_SYSCK): drvOut[p] = sysClockOut;
				3'(pcpio_pkg::F_MISO): drvOut[p] = 1'b1; // input: released
				default: drvOut[p] = latch_r[p]; // R06
			endcase
		end
		if (en && en0_r[pcpio_pkg::BIT_UART]) begin
			drvOut[pcpio_pkg::PIN_UTX] = uartTx; // R03
			drvOut[pcpio_pkg::PIN_URX] = 1'b1;
			pinIsIn[pcpio_pkg::PIN_URX] = 1'b1; // R03
		end
		if (en && en0_r[pcpio_pkg::BIT_CMPA]) drvOut[pcpio_pkg::PIN_CMPA] = cmpAsyncOut; // R04
		if (en && en0_r[pcpio_pkg::BIT_CMPS]) drvOut[pcpio_pkg::PIN_CMPS] = cmpSyncOut; // R04
		isOd = ~mdout_r | pinIsMgmt; // R10 R11
		for (int p = 0; p < pcpio_pkg::NPINS; p++) begin
			out_nxt[p] = drvOut[p];
			// open-drain drives only its low level
			oe_nxt[p] = en && mdin_r[p] && !pinIsIn[p] && (!isOd[p] || !drvOut[p]); // R08 R14
			pu_nxt[p] = mdin_r[p] && isOd[p] && !ctl1_r[pcpio_pkg::BIT_PUDIS]
				&& !(oe_nxt[p] && !drvOut[p]); // R12 R13 R08
			din_nxt[p] = mdin_r[p]; // R08
		end
	end

	// peripheral inputs from their pins
	always_comb begin
		spiMisoIn = 1'b1;
		mgmtSdaIn = 1'b1;
		mgmtSclIn = 1'b1;
		for (int p = 0; p < pcpio_pkg::NPINS; p++) begin
			if (pinFunc[p] == 3'(pcpio_pkg::F_MISO)) spiMisoIn = pinInQ[p];
			if (pinFunc[p] == 3'(pcpio_pkg::F_SDA)) mgmtSdaIn = pinInQ[p];
			if (pinFunc[p] == 3'(pcpio_pkg::F_SCL)) mgmtSclIn = pinInQ[p];
		end
	end

	logic uartRx_nxt;
	always_comb uartRx_nxt = (ctl1_r[pcpio_pkg::BIT_ROUTER] && en0_r[pcpio_pkg::BIT_UART])
		? pinInQ[pcpio_pkg::PIN_URX] : 1'b1; // R03

	always_ff @(posedge clk) begin
		if (rst) begin
			en0_r <= pcpio_pkg::EN0_RST;
			ctl1_r <= pcpio_pkg::CTL1_RST; // R19
			mdin_r <= {2{pcpio_pkg::MDIN_RST}}; // R09
			mdout_r <= {2{pcpio_pkg::MDOUT_RST}};
			skip_r <= {2{pcpio_pkg::SKIP_RST}};
			latch_r <= {2{pcpio_pkg::PORT_RST}};
			regRdata <= 8'h00;
			pinOut <= 16'h0000;
			pinOe <= 16'h0000;
			pinPullup <= 16'h0000;
			pinDigIn <= 16'hffff;
			uartRx <= 1'b1;
		end else begin
			en0_r <= en0_nxt;
			ctl1_r <= ctl1_nxt;
			mdin_r <= mdin_nxt;
			mdout_r <= mdout_nxt;
			skip_r <= skip_nxt;
			latch_r <= latch_nxt;
			regRdata <= rdata_nxt;
			pinOut <= out_nxt;
			pinOe <= oe_nxt;
			pinPullup <= pu_nxt;
			pinDigIn <= din_nxt;
			uartRx <= uartRx_nxt;
		end
	end

	a_disabled_no_drive: assert property (@(posedge clk) disable iff (rst) // R14
		!ctl1_r[pcpio_pkg::BIT_ROUTER] |=> pinOe == 16'h0000)
		else $error("driver on while router disabled");
	a_analog_pin_quiet: assert property (@(posedge clk) disable iff (rst) // R08
		1'b1 |=> ((pinOe | pinPullup | pinDigIn) & ~$past(mdin_r)) == 16'h0000)
		else $error("analog pin not quiet");
	a_pullup_low_off: assert property (@(posedge clk) disable iff (rst) // R13
		(pinOe & ~pinOut & pinPullup) == 16'h0000)
		else $error("pull-up on low-driving pin");
	a_pushpull_no_pu: assert property (@(posedge clk) disable iff (rst) // R12
		1'b1 |=> (pinPullup & $past(mdout_r & ~pinIsMgmt)) == 16'h0000)
		else $error("pull-up on push-pull pin");
	a_uart_tx_fixed: assert property (@(posedge clk) disable iff (rst) // R03
		(ctl1_r[pcpio_pkg::BIT_ROUTER] && en0_r[pcpio_pkg::BIT_UART])
		|=> pinOut[pcpio_pkg::PIN_UTX] == $past(uartTx))
		else $error("uart transmit not on its pin");
	a_uart_rx_released: assert property (@(posedge clk) disable iff (rst) // R03
		(ctl1_r[pcpio_pkg::BIT_ROUTER] && en0_r[pcpio_pkg::BIT_UART])
		|=> !pinOe[pcpio_pkg::PIN_URX])
		else $error("uart receive pin driven");
	a_rd_pin_level: assert property (@(posedge clk) disable iff (rst) // R15
		(regRd && !regRmw && regAddr == pcpio_pkg::ADDR_PORT0)
		|=> regRdata == $past(pinIn[7:0] & mdin_r[7:0]))
		else $error("port read not pin level");
	a_rmw_latch: assert property (@(posedge clk) disable iff (rst) // R20
		(regRd && regRmw && regAddr == pcpio_pkg::ADDR_PORT1)
		|=> regRdata == $past(latch_r[15:8]))
		else $error("rmw read not latch");
	a_first_pin_spi: assert property (@(posedge clk) disable iff (rst) // R01 R02
		(ctl1_r[pcpio_pkg::BIT_ROUTER] && en0_r[pcpio_pkg::BIT_SPI] && !skip_r[0])
		|-> pinFunc[0] == 3'(pcpio_pkg::F_SCK))
		else $error("spi clock not on lowest free pin");
endmodule // pcpio_crossbar

// ===== hdl/pcpio_pkg.sv
// constants for the priority crossbar port block
// Overview of operation
// [R01] enabled functions get lowest free non-skipped pin, in priority order from uart
// [R02] skip-marked pins are passed over exactly like assigned pins
// [R03] uart transmit fixed on P0.4, receive fixed on P0.5
// [R04] async comparator output only P1.4, sync comparator output only P1.5
// [R05] management bus takes data and clock pins; uart takes both its pins
// [R06] pins left after allocation stay general-purpose port pins
// [R07] spi takes three pins, four when slave select mode is four-wire
// [R08] analog pin: pull-up, output driver and digital receiver all off
// [R09] input mode bit 1 digital, 0 analog; reset value digital
// [R10] open-drain or push-pull from output mode bit, never changed automatically; management bus pins are forced open-drain
// [R11] management bus pins always drive open-drain
// [R12] pull-up on open-drain pins while pullup_disable is 0; none on push-pull
// [R13] pull-up off on any pin driving low
// [R14] router disabled: all pins inputs, every driver off
// [R15] port read returns pin levels, even for peripheral pins
// [R16] software skips pins claimed outside the crossbar
// [R17] software skips analog input pins
// [R18] software sets modes, skips, assignments, then router enable
// [R19] router_enable bit 6, pullup_disable bit 7 of control 1, reset zero
// [R20] read-modify-write of a port reads the latch, not the pins
package pcpio_pkg;
	localparam int NPINS = 16;
	localparam logic [7:0] ADDR_XBR_EN0 = 8'he1;
	localparam logic [7:0] ADDR_XBR_CTL1 = 8'he2;
	localparam logic [7:0] ADDR_PORT0 = 8'h80;
	localparam logic [7:0] ADDR_PORT1 = 8'h90;
	localparam logic [7:0] ADDR_MDIN0 = 8'hf1;
	localparam logic [7:0] ADDR_MDIN1 = 8'hf2;
	localparam logic [7:0] ADDR_MDOUT0 = 8'ha4;
	localparam logic [7:0] ADDR_MDOUT1 = 8'ha5;
	localparam logic [7:0] ADDR_SKIP0 = 8'hd4;
	localparam logic [7:0] ADDR_SKIP1 = 8'hd5;
	localparam logic [7:0] EN0_RST = 8'h00;
	localparam logic [7:0] EN0_MASK = 8'h3f;
	localparam logic [7:0] CTL1_RST = 8'h00;
	localparam logic [7:0] MDIN_RST = 8'hff;
	localparam logic [7:0] MDOUT_RST = 8'h00;
	localparam logic [7:0] SKIP_RST = 8'h00;
	localparam logic [7:0] PORT_RST = 8'hff;
	localparam int BIT_UART = 0;
	localparam int BIT_SPI = 1;
	localparam int BIT_MGMT = 2;
	localparam int BIT_SYSCK = 3;
	localparam int BIT_CMPS = 4;
	localparam int BIT_CMPA = 5;
	localparam int BIT_ROUTER = 6;
	localparam int BIT_PUDIS = 7;
	localparam int PIN_UTX = 4;
	localparam int PIN_URX = 5;
	localparam int PIN_CMPA = 12;
	localparam int PIN_CMPS = 13;
	localparam logic [1:0] SS_FOUR_WIRE = 2'h1;
	localparam int NFUNC = 6;
	// routed function order after fixed uart
	localparam int F_SCK = 0;
	localparam int F_MISO = 1;
	localparam int F_MOSI = 2;
	localparam int F_NSS = 3;
	localparam int F_SDA = 4;
	localparam int F_SCL = 5;
	localparam int F_SYSCK = 6;
	localparam int F_NONE = 7;
endpackage

// ===== testbench/pcpio_pin_model.sv
// external pin levels seen by the crossbar: design drive, far-side drive, pull-ups
`timescale 1ns/10ps
module pcpio_pin_model (
	// clock
	input wire logic clk,
	// design pin side
	input wire logic [15:0] pinOut,
	input wire logic [15:0] pinOe,
	input wire logic [15:0] pinPullup,
	// far side drive
	input wire logic [15:0] extVal,
	input wire logic [15:0] extEn,
	// resolved levels
	output logic [15:0] pinIn
);
	logic [15:0] lastLvl_r = 16'h0000;
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			if (pinOe[i]) pinIn[i] = pinOut[i];
			else if (extEn[i]) pinIn[i] = extVal[i];
			else if (pinPullup[i]) pinIn[i] = 1'b1;
			// floating line flips each cycle so a stale level never looks valid
			else pinIn[i] = ~lastLvl_r[i];
		end
	end
	always_ff @(posedge clk) begin
		lastLvl_r <= pinIn;
	end
endmodule // pcpio_pin_model

// ===== testbench/testbench.sv
// self-checking bench for the priority crossbar port block
`timescale 1ns/10ps
module testbench;
	logic clk, rst, regWr, regRd, regRmw, uartTx, spiSck, spiMosi, spiSlaveSel;
	logic mgmtSdaOut, mgmtSclOut, sysClockOut, cmpAsyncOut, cmpSyncOut;
	logic uartRx, spiMisoIn, mgmtSdaIn, mgmtSclIn;
	logic [1:0] slaveSelectMode;
	logic [7:0] regAddr, regWdata, regRdata;
	logic [15:0] pinIn, pinOut, pinOe, pinPullup, pinDigIn, extVal, extEn;
	int miscompares = 0;
	int checks_done = 0;
	pcpio_crossbar dut_u (.clk(clk), .rst(rst), .regAddr(regAddr), .regWr(regWr),
		.regRd(regRd), .regRmw(regRmw), .regWdata(regWdata), .regRdata(regRdata),
		.uartTx(uartTx), .uartRx(uartRx), .spiSck(spiSck), .spiMisoIn(spiMisoIn),
		.spiMosi(spiMosi), .spiSlaveSel(spiSlaveSel), .slaveSelectMode(slaveSelectMode),
		.mgmtSdaOut(mgmtSdaOut), .mgmtSdaIn(mgmtSdaIn), .mgmtSclOut(mgmtSclOut),
		.mgmtSclIn(mgmtSclIn), .sysClockOut(sysClockOut), .cmpAsyncOut(cmpAsyncOut),
		.cmpSyncOut(cmpSyncOut), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
		.pinPullup(pinPullup), .pinDigIn(pinDigIn));
	pcpio_pin_model pins_u (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
		.pinPullup(pinPullup), .extVal(extVal), .extEn(extEn), .pinIn(pinIn));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic rmw, input logic [7:0] exp);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		regRmw <= rmw;
		@(posedge clk);
		regRd <= 1'b0;
		regRmw <= 1'b0;
		#1 chk({8'h00, regRdata}, {8'h00, exp});
	endtask
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask
	// drive state of one pin; out only matters while driving
	task automatic pc(input int i, input logic oe, input logic out);
		chk({14'h0, pinOe[i], pinOe[i] & pinOut[i]}, {14'h0, oe, out});
	endtask
	task automatic t_reset();
		rdc(pcpio_pkg::ADDR_XBR_EN0, 1'b0, pcpio_pkg::EN0_RST);
		rdc(pcpio_pkg::ADDR_XBR_CTL1, 1'b0, pcpio_pkg::CTL1_RST);
		rdc(pcpio_pkg::ADDR_MDIN0, 1'b0, 8'hff);
		rdc(pcpio_pkg::ADDR_MDOUT0, 1'b0, pcpio_pkg::MDOUT_RST);
		rdc(pcpio_pkg::ADDR_SKIP0, 1'b0, pcpio_pkg::SKIP_RST);
		rdc(8'h33, 1'b0, 8'h00);
		chk(pinOe, 16'h0000);
		chk(pinDigIn, 16'hffff);
	endtask
	task automatic t_disabled();
		wr(pcpio_pkg::ADDR_XBR_EN0, 8'hff);
		rdc(pcpio_pkg::ADDR_XBR_EN0, 1'b0, 8'h3f);
		settle();
		chk(pinOe, 16'h0000);
	endtask
	task automatic t_route3();
		wr(pcpio_pkg::ADDR_MDIN1, 8'h7f);
		wr(pcpio_pkg::ADDR_MDOUT0, 8'hff);
		wr(pcpio_pkg::ADDR_SKIP0, 8'h0c);
		wr(pcpio_pkg::ADDR_SKIP1, 8'hb0);
		wr(pcpio_pkg::ADDR_XBR_CTL1, 8'h40);
		settle();
		pc(0, 1'b1, 1'b1);
		pc(1, 1'b0, 1'b0);
		pc(4, 1'b1, 1'b1);
		pc(6, 1'b1, 1'b0);
		pc(7, 1'b1, 1'b0);
		chk(pinPullup[7], 1'b0);
		pc(8, 1'b0, 1'b0);
		chk(pinPullup[8], 1'b1);
		chk(pinPullup[0], 1'b0);
		pc(9, 1'b1, 1'b0);
		pc(12, 1'b1, 1'b0);
		pc(13, 1'b0, 1'b0);
		pc(10, 1'b0, 1'b0);
		chk({pinDigIn[15], pinPullup[15], pinOe[15]}, 3'h0);
	endtask
	task automatic t_route4();
		@(posedge clk);
		slaveSelectMode <= pcpio_pkg::SS_FOUR_WIRE;
		spiSlaveSel <= 1'b1;
		settle();
		pc(7, 1'b1, 1'b1);
		pc(8, 1'b1, 1'b0);
		pc(9, 1'b0, 1'b0);
		pc(10, 1'b1, 1'b0);
	endtask
	task automatic t_input();
		@(posedge clk);
		extEn <= 16'h0022;
		extVal <= 16'h0000;
		settle();
		chk({uartRx, spiMisoIn, mgmtSdaIn, mgmtSclIn}, 4'h1);
		rdc(pcpio_pkg::ADDR_PORT0, 1'b0, 8'h9d);
		rdc(pcpio_pkg::ADDR_PORT0, 1'b1, pcpio_pkg::PORT_RST);
		rdc(pcpio_pkg::ADDR_PORT1, 1'b1, pcpio_pkg::PORT_RST);
	endtask
	task automatic t_port();
		wr(pcpio_pkg::ADDR_PORT1, 8'h00);
		settle();
		pc(11, 1'b1, 1'b0);
		chk(pinPullup[11], 1'b0);
		wr(pcpio_pkg::ADDR_XBR_CTL1, 8'hc0);
		wr(pcpio_pkg::ADDR_PORT1, 8'hff);
		settle();
		chk({pinOe[11], pinPullup[11], pinPullup[14]}, 3'h0);
		wr(pcpio_pkg::ADDR_XBR_CTL1, 8'h00);
		settle();
		chk(pinOe, 16'h0000);
	endtask
	task automatic stop_test();
		$display("mismatches %0d of %0d checks", miscompares, checks_done);
		if (miscompares == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// whole sequence is under a hundred cycles; generous margin
	initial begin
		#100us;
		miscompares++;
		stop_test();
	end
	initial begin
		{regWr, regRd, regRmw, spiMosi, spiSlaveSel, mgmtSdaOut, sysClockOut} = 7'h00;
		{uartTx, spiSck, mgmtSclOut, cmpSyncOut, cmpAsyncOut} = 5'h1e;
		slaveSelectMode = 2'h0;
		regAddr = 8'h00;
		regWdata = 8'h00;
		extVal = 16'h0000;
		extEn = 16'h0000;
		rst = 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_disabled();
		t_route3();
		t_route4();
		t_input();
		t_port();
		stop_test();
	end
endmodule // testbench
